/* File: logic/fpc_pkg.sv */
package fpc_pkg;

	// ==========================================================
	// register offsets (byte addresses, one aligned word each)
	localparam logic [7:0] ADR_CTRL  = 8'h00;
	localparam logic [7:0] ADR_STAT  = 8'h04;
	localparam logic [7:0] ADR_ACC   = 8'h08;
	localparam logic [7:0] ADR_UCL   = 8'h0C;
	localparam logic [7:0] ADR_LCL   = 8'h10;
	localparam logic [7:0] ADR_UTV   = 8'h14;
	localparam logic [7:0] ADR_LTV   = 8'h18;
	localparam logic [7:0] ADR_MASK  = 8'h1C;
	localparam logic [7:0] ADR_UPAT  = 8'h20;
	localparam logic [7:0] ADR_LPAT  = 8'h24;
	localparam logic [7:0] ADR_ISTAT = 8'h28;
	localparam logic [7:0] ADR_IMASK = 8'h2C;

	// ==========================================================
	// field positions
	localparam int CTRL_EN_BIT     = 0;
	localparam int CTRL_SIZE_LSB   = 1;
	localparam int STAT_ACTIVE_BIT = 0;
	localparam int STAT_FAULT_BIT  = 1;
	localparam int STAT_CODE_LSB   = 4;
	localparam int IRQ_OVF         = 0;
	localparam int IRQ_UNF         = 1;
	localparam int IRQ_UTGT        = 2;
	localparam int IRQ_LTGT        = 3;
	localparam int IRQ_FAULT       = 4;
	localparam int IRQ_W           = 5;
	localparam int OUT_W           = 20;

	// ==========================================================
	// reset values
	localparam logic [31:0] UCL_RST  = 32'h7FFFFFFF;
	localparam logic [31:0] LCL_RST  = 32'h80000000;
	localparam logic [31:0] UTV_RST  = 32'h7FFFFFFF;
	localparam logic [31:0] LTV_RST  = 32'h80000000;
	localparam logic [31:0] WORD_RST = 32'h00000000;

	// ==========================================================
	// enumerations
	typedef enum logic [1:0] {
		SZ_4  = 2'b00,
		SZ_6  = 2'b01,
		SZ_10 = 2'b10,
		SZ_20 = 2'b11
	} fpc_size_t;

	typedef enum logic [3:0] {
		FLT_NONE    = 4'b0000,
		FLT_LCL_LTV = 4'b0001,
		FLT_UTV_UCL = 4'b0010,
		FLT_LCL_UCL = 4'b0011
	} fpc_fault_t;

	typedef enum logic [0:0] {
		BUS_IDLE = 1'b0,
		BUS_ACK  = 1'b1
	} fpc_bus_t;

endpackage

/* File: logic/fpc_link_if.sv */
`timescale 1ns/10ps
interface fpc_link_if;
	logic                          en;
	logic                          up;
	logic                          dn;
	logic                          ld;
	logic [31:0]                   ld_val;
	logic [31:0]                   ucl;
	logic [31:0]                   lcl;
	logic [31:0]                   utv;
	logic [31:0]                   ltv;
	logic [31:0]                   acc;
	logic                          ovf;
	logic                          unf;
	logic                          hit_u;
	logic                          hit_l;
	logic [fpc_pkg::OUT_W-1:0]     mask;
	logic [fpc_pkg::OUT_W-1:0]     upat;
	logic [fpc_pkg::OUT_W-1:0]     lpat;
	logic [fpc_pkg::OUT_W-1:0]     prog;
	logic [fpc_pkg::OUT_W-1:0]     pins;

	modport ctl (output en, up, dn, ld, ld_val, ucl, lcl, utv, ltv, mask, upat, lpat, prog,
		input acc, ovf, unf, hit_u, hit_l, pins);
	modport cnt (input en, up, dn, ld, ld_val, ucl, lcl, utv, ltv,
		output acc, ovf, unf, hit_u, hit_l);
	modport drv (input hit_u, hit_l, mask, upat, lpat, prog, output pins);
endinterface

/* File: logic/fpc_count_core.sv */
`timescale 1ns/10ps
module fpc_count_core (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// link to the register side
	fpc_link_if.cnt   lk
);
	typedef struct packed {
		logic [31:0] acc;
		logic        ovf;
		logic        unf;
		logic        hit_u;
		logic        hit_l;
	} fpc_core_st_t;

	fpc_core_st_t s_r;
	fpc_core_st_t s_nxt;

	always_comb begin
		s_nxt       = s_r;
		s_nxt.ovf   = 1'b0;
		s_nxt.unf   = 1'b0;
		s_nxt.hit_u = 1'b0;
		s_nxt.hit_l = 1'b0;
		if (lk.ld) begin
			s_nxt.acc = lk.ld_val;
		end else if (lk.en && (lk.up ^ lk.dn)) begin
			if (lk.up) begin
				if ($signed(s_r.acc) >= $signed(lk.ucl)) begin
					s_nxt.acc = lk.lcl;
					s_nxt.ovf = 1'b1;
				end else begin
					s_nxt.acc = s_r.acc + 32'h00000001;
				end
			end else begin
				if ($signed(s_r.acc) <= $signed(lk.lcl)) begin
					s_nxt.acc = lk.ucl;
					s_nxt.unf = 1'b1;
				end else begin
					s_nxt.acc = s_r.acc - 32'h00000001;
				end
			end
			s_nxt.hit_u = (s_nxt.acc == lk.utv);
			s_nxt.hit_l = (s_nxt.acc == lk.ltv);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign lk.acc   = s_r.acc;
	assign lk.ovf   = s_r.ovf;
	assign lk.unf   = s_r.unf;
	assign lk.hit_u = s_r.hit_u;
	assign lk.hit_l = s_r.hit_l;
endmodule

/* File: logic/fpc_out_drive.sv */
`timescale 1ns/10ps
module fpc_out_drive (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// link to the register side
	fpc_link_if.drv   lk
);
	typedef struct packed {
		logic [fpc_pkg::OUT_W-1:0] held;
		logic [fpc_pkg::OUT_W-1:0] pins;
	} fpc_drv_st_t;

	fpc_drv_st_t s_r;
	fpc_drv_st_t s_nxt;

	always_comb begin
		s_nxt = s_r;
		// lower target applied first so an upper hit in the same cycle wins
		if (lk.hit_l) begin
			s_nxt.held = (s_nxt.held & ~lk.mask) | (lk.lpat & lk.mask);
		end
		if (lk.hit_u) begin
			s_nxt.held = (s_nxt.held & ~lk.mask) | (lk.upat & lk.mask);
		end
		// owned bits hold, unowned bits follow the program
		s_nxt.pins = (s_nxt.held & lk.mask) | (lk.prog & ~lk.mask);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign lk.pins = s_r.pins;
endmodule

/* File: logic/fpc_top.sv */
// Notes on behaviour
// - counting down past the lower limit raises an underflow event.
// - on underflow the accumulator reloads the upper limit, no pulse lost.
// - a lower limit above the lower target flags a configuration fault.
// - mask bit n owns embedded output n.
// - owned outputs may be switched by the counter, others never.
// - owned outputs switch in hardware when either target is reached.
// - on upper target, owned outputs take the upper pattern bits.
// - on lower target, owned outputs take the lower pattern bits.
// - the pattern is filtered bitwise through the ownership mask.
// - both patterns may be rewritten at setup or while running.
// - only 4, 6, 10 or 20 low mask bits act, per controller size.
// - read-only counting-active bit, zero after reset.
// - fault-present bit set on any error, with a reason code, clearable.
// - counting up past the upper limit overflows and reloads the lower limit.
// - reaching the upper target raises an event.
// - reaching the lower target raises an event.
//
// Added by the designer: the Wishbone register port and the register offsets.
`timescale 1ns/10ps
module fpc_top (
	// clock and reset
	input  wire logic                      clk_i,
	input  wire logic                      rst_i,
	// wishbone slave
	input  wire logic                      cyc_i,
	input  wire logic                      stb_i,
	input  wire logic                      we_i,
	input  wire logic [7:0]                adr_i,
	input  wire logic [3:0]                sel_i,
	input  wire logic [31:0]               dat_i,
	output logic      [31:0]               dat_o,
	output logic                           ack_o,
	// field pulse inputs
	input  wire logic                      pulse_up_i,
	input  wire logic                      pulse_dn_i,
	// embedded outputs
	input  wire logic [fpc_pkg::OUT_W-1:0] prog_out_i,
	output logic      [fpc_pkg::OUT_W-1:0] out_o,
	// interrupt
	output logic                           irq_o
);

	// ==========================================================
	// state
	typedef struct packed {
		fpc_pkg::fpc_bus_t           bus;
		logic [31:0]                 rdat;
		logic                        en;
		fpc_pkg::fpc_size_t          size;
		logic [31:0]                 ucl;
		logic [31:0]                 lcl;
		logic [31:0]                 utv;
		logic [31:0]                 ltv;
		logic [31:0]                 mask;
		logic [31:0]                 upat;
		logic [31:0]                 lpat;
		logic                        fault;
		fpc_pkg::fpc_fault_t         code;
		logic                        err_d;
		logic [fpc_pkg::IRQ_W-1:0]   istat;
		logic [fpc_pkg::IRQ_W-1:0]   imask;
		logic                        irq;
		logic [2:0]                  up_sy;
		logic [2:0]                  dn_sy;
		logic                        ld;
		logic [31:0]                 ld_val;
	} fpc_top_st_t;

	fpc_top_st_t s_r;
	fpc_top_st_t s_nxt;

	fpc_link_if lk ();

	// ==========================================================
	// submodules
	fpc_count_core u_core (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.lk    (lk)
	);

	fpc_out_drive u_drv (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.lk    (lk)
	);

	// ==========================================================
	// combinational helpers
	logic                        req;
	logic                        wr;
	logic [31:0]                 bmask;
	fpc_pkg::fpc_fault_t         cfg_err;
	logic                        active;
	logic [fpc_pkg::OUT_W-1:0]   mask_eff;
	logic [fpc_pkg::OUT_W-1:0]   width_m;
	logic [fpc_pkg::IRQ_W-1:0]   ev;

	// byte enables widened to a bit mask
	genvar gb;
	generate
		for (gb = 0; gb < 4; gb++) begin : g_sel
			assign bmask[gb*8 +: 8] = {8{sel_i[gb]}};
		end
	endgenerate

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [31:0] bm);
		merge = (old & ~bm) | (nw & bm);
	endfunction

	// functional outputs per controller size
	always_comb begin
		case (s_r.size)
			fpc_pkg::SZ_4: begin
				width_m = 20'h0000F;
			end
			fpc_pkg::SZ_6: begin
				width_m = 20'h0003F;
			end
			fpc_pkg::SZ_10: begin
				width_m = 20'h003FF;
			end
			fpc_pkg::SZ_20: begin
				width_m = 20'hFFFFF;
			end
			default: begin
				width_m = 20'h00000;
			end
		endcase
	end

	assign mask_eff = s_r.mask[fpc_pkg::OUT_W-1:0] & width_m;

	// configuration ordering checks, lowest code wins
	always_comb begin
		if ($signed(s_r.lcl) > $signed(s_r.ltv)) begin
			cfg_err = fpc_pkg::FLT_LCL_LTV;
		end else if ($signed(s_r.utv) > $signed(s_r.ucl)) begin
			cfg_err = fpc_pkg::FLT_UTV_UCL;
		end else if ($signed(s_r.lcl) >= $signed(s_r.ucl)) begin
			cfg_err = fpc_pkg::FLT_LCL_UCL;
		end else begin
			cfg_err = fpc_pkg::FLT_NONE;
		end
	end

	// counting stops while the configuration is inconsistent
	assign active = s_r.en && (cfg_err == fpc_pkg::FLT_NONE);

	assign req = cyc_i && stb_i;
	// writes land at the edge where the master samples ack
	assign wr  = req && we_i && (s_r.bus == fpc_pkg::BUS_ACK);

	// events from the counter and the fault check
	always_comb begin
		ev                       = '0;
		ev[fpc_pkg::IRQ_OVF]     = lk.ovf;
		ev[fpc_pkg::IRQ_UNF]     = lk.unf;
		ev[fpc_pkg::IRQ_UTGT]    = lk.hit_u;
		ev[fpc_pkg::IRQ_LTGT]    = lk.hit_l;
		ev[fpc_pkg::IRQ_FAULT]   = (cfg_err != fpc_pkg::FLT_NONE) && !s_r.err_d;
	end

	// ==========================================================
	// next state
	always_comb begin
		s_nxt       = s_r;
		s_nxt.ld    = 1'b0;
		s_nxt.err_d = (cfg_err != fpc_pkg::FLT_NONE);

		// two flops then an edge detector on the settled copy
		s_nxt.up_sy = {s_r.up_sy[1:0], pulse_up_i};
		s_nxt.dn_sy = {s_r.dn_sy[1:0], pulse_dn_i};

		// bus handshake: ack one cycle after the request, drop it next
		case (s_r.bus)
			fpc_pkg::BUS_IDLE: begin
				if (req) begin
					s_nxt.bus = fpc_pkg::BUS_ACK;
				end
			end
			fpc_pkg::BUS_ACK: begin
				s_nxt.bus = fpc_pkg::BUS_IDLE;
			end
			default: begin
				s_nxt.bus = fpc_pkg::BUS_IDLE;
			end
		endcase

		// read data captured with the ack
		s_nxt.rdat = 32'h00000000;
		if (req && (s_r.bus == fpc_pkg::BUS_IDLE)) begin
			case (adr_i)
				fpc_pkg::ADR_CTRL: begin
					s_nxt.rdat[fpc_pkg::CTRL_EN_BIT] = s_r.en;
					s_nxt.rdat[fpc_pkg::CTRL_SIZE_LSB +: 2] = s_r.size;
				end
				fpc_pkg::ADR_STAT: begin
					s_nxt.rdat[fpc_pkg::STAT_ACTIVE_BIT] = active;
					s_nxt.rdat[fpc_pkg::STAT_FAULT_BIT] = s_r.fault;
					s_nxt.rdat[fpc_pkg::STAT_CODE_LSB +: 4] = s_r.code;
				end
				fpc_pkg::ADR_ACC: begin
					s_nxt.rdat = lk.acc;
				end
				fpc_pkg::ADR_UCL: begin
					s_nxt.rdat = s_r.ucl;
				end
				fpc_pkg::ADR_LCL: begin
					s_nxt.rdat = s_r.lcl;
				end
				fpc_pkg::ADR_UTV: begin
					s_nxt.rdat = s_r.utv;
				end
				fpc_pkg::ADR_LTV: begin
					s_nxt.rdat = s_r.ltv;
				end
				fpc_pkg::ADR_MASK: begin
					s_nxt.rdat = s_r.mask;
				end
				fpc_pkg::ADR_UPAT: begin
					s_nxt.rdat = s_r.upat;
				end
				fpc_pkg::ADR_LPAT: begin
					s_nxt.rdat = s_r.lpat;
				end
				fpc_pkg::ADR_ISTAT: begin
					s_nxt.rdat[fpc_pkg::IRQ_W-1:0] = s_r.istat;
				end
				fpc_pkg::ADR_IMASK: begin
					s_nxt.rdat[fpc_pkg::IRQ_W-1:0] = s_r.imask;
				end
				default: begin
					s_nxt.rdat = 32'h00000000;
				end
			endcase
		end

		// register writes
		if (wr) begin
			case (adr_i)
				fpc_pkg::ADR_CTRL: begin
					if (sel_i[0]) begin
						s_nxt.en   = dat_i[fpc_pkg::CTRL_EN_BIT];
						s_nxt.size = fpc_pkg::fpc_size_t'(dat_i[fpc_pkg::CTRL_SIZE_LSB +: 2]);
					end
				end
				fpc_pkg::ADR_ACC: begin
					s_nxt.ld     = 1'b1;
					s_nxt.ld_val = merge(lk.acc, dat_i, bmask);
				end
				fpc_pkg::ADR_UCL: begin
					s_nxt.ucl = merge(s_r.ucl, dat_i, bmask);
				end
				fpc_pkg::ADR_LCL: begin
					s_nxt.lcl = merge(s_r.lcl, dat_i, bmask);
				end
				fpc_pkg::ADR_UTV: begin
					s_nxt.utv = merge(s_r.utv, dat_i, bmask);
				end
				fpc_pkg::ADR_LTV: begin
					s_nxt.ltv = merge(s_r.ltv, dat_i, bmask);
				end
				fpc_pkg::ADR_MASK: begin
					s_nxt.mask = merge(s_r.mask, dat_i, bmask);
				end
				fpc_pkg::ADR_UPAT: begin
					s_nxt.upat = merge(s_r.upat, dat_i, bmask);
				end
				fpc_pkg::ADR_LPAT: begin
					s_nxt.lpat = merge(s_r.lpat, dat_i, bmask);
				end
				fpc_pkg::ADR_ISTAT: begin
					if (sel_i[0]) begin
						s_nxt.istat = s_r.istat & ~dat_i[fpc_pkg::IRQ_W-1:0];
					end
				end
				fpc_pkg::ADR_STAT: begin
					if (sel_i[0] && dat_i[fpc_pkg::STAT_FAULT_BIT]) begin
						s_nxt.fault = 1'b0;
					end
				end
				fpc_pkg::ADR_IMASK: begin
					if (sel_i[0]) begin
						s_nxt.imask = dat_i[fpc_pkg::IRQ_W-1:0];
					end
				end
				default: begin
				end
			endcase
		end

		// hardware sets win over software clears
		s_nxt.istat = s_nxt.istat | ev;
		if (cfg_err != fpc_pkg::FLT_NONE) begin
			s_nxt.fault = 1'b1;
			s_nxt.code  = cfg_err;
		end

		s_nxt.irq = |(s_nxt.istat & s_nxt.imask);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_r       <= '0;
			s_r.ucl   <= fpc_pkg::UCL_RST;
			s_r.lcl   <= fpc_pkg::LCL_RST;
			s_r.utv   <= fpc_pkg::UTV_RST;
			s_r.ltv   <= fpc_pkg::LTV_RST;
			s_r.mask  <= fpc_pkg::WORD_RST;
			s_r.upat  <= fpc_pkg::WORD_RST;
			s_r.lpat  <= fpc_pkg::WORD_RST;
			s_r.size  <= fpc_pkg::SZ_4;
			s_r.code  <= fpc_pkg::FLT_NONE;
			s_r.bus   <= fpc_pkg::BUS_IDLE;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ==========================================================
	// link wiring
	assign lk.en     = active;
	assign lk.up     = s_r.up_sy[1] && !s_r.up_sy[2];
	assign lk.dn     = s_r.dn_sy[1] && !s_r.dn_sy[2];
	assign lk.ld     = s_r.ld;
	assign lk.ld_val = s_r.ld_val;
	assign lk.ucl    = s_r.ucl;
	assign lk.lcl    = s_r.lcl;
	assign lk.utv    = s_r.utv;
	assign lk.ltv    = s_r.ltv;
	assign lk.mask   = mask_eff;
	assign lk.upat   = s_r.upat[fpc_pkg::OUT_W-1:0];
	assign lk.lpat   = s_r.lpat[fpc_pkg::OUT_W-1:0];
	assign lk.prog   = prog_out_i;

	// ==========================================================
	// outputs
	assign dat_o = s_r.rdat;
	assign ack_o = (s_r.bus == fpc_pkg::BUS_ACK);
	assign out_o = lk.pins;
	assign irq_o = s_r.irq;

endmodule

/* File: dv/fpc_field_model.sv */
`timescale 1ns/10ps
// ========
// field pulse source and program output driver
module fpc_field_model (
	// clock
	input  wire logic        clk_i,
	// command from the bench
	input  wire logic        go_i,
	input  wire logic        dn_i,
	input  wire logic [7:0]  num_i,
	input  wire logic [3:0]  gap_i,
	// field side
	output logic             pulse_up_o,
	output logic             pulse_dn_o,
	output logic [19:0]      prog_o,
	output logic             busy_o
);
	int n = 0;
	int ph = 0;
	initial begin
		pulse_up_o = 1'b0;
		pulse_dn_o = 1'b0;
		prog_o = 20'h00000;
		busy_o = 1'b0;
	end
	always @(posedge clk_i) begin
		// program outputs change every cycle so a stale copy never matches
		prog_o <= prog_o + 20'h1F3B7;
		if (!busy_o && go_i) begin
			n = num_i;
			ph = 0;
		end else if (n > 0) begin
			ph = ph + 1;
			if (ph > 3 + gap_i) begin
				ph = 0;
				n = n - 1;
			end
		end
		busy_o <= (n > 0);
		// pin high 2 cycles, low 2 plus gap cycles
		pulse_up_o <= (n > 0) && (ph < 2) && !dn_i;
		pulse_dn_o <= (n > 0) && (ph < 2) && dn_i;
	end
endmodule

/* File: dv/fpc_props.sv */
`timescale 1ns/10ps
module fpc_props (
	// clock and reset
	input  wire logic                      clk_i,
	input  wire logic                      rst_i,
	// wishbone
	input  wire logic                      cyc_i,
	input  wire logic                      stb_i,
	input  wire logic                      we_i,
	input  wire logic [7:0]                adr_i,
	input  wire logic [3:0]                sel_i,
	input  wire logic [31:0]               dat_i,
	input  wire logic [31:0]               dat_o,
	input  wire logic                      ack_o,
	// field side
	input  wire logic                      pulse_up_i,
	input  wire logic                      pulse_dn_i,
	input  wire logic [fpc_pkg::OUT_W-1:0] prog_out_i,
	input  wire logic [fpc_pkg::OUT_W-1:0] out_o,
	input  wire logic                      irq_o
);
	// ========
	// shadow of the output setup, rebuilt from bus writes
	logic [31:0] mask_r, upat_r, lpat_r;
	logic [1:0]  size_r;
	logic [4:0]  imask_r;
	logic [2:0]  quiet_r;
	logic [3:0]  idle_r;
	logic [19:0] size_m, eff;
	logic        wr;
	assign wr = cyc_i && stb_i && we_i && ack_o;
	always_comb begin
		case (size_r)
			2'b00: size_m = 20'h0000F;
			2'b01: size_m = 20'h0003F;
			2'b10: size_m = 20'h003FF;
			default: size_m = 20'hFFFFF;
		endcase
	end
	assign eff = mask_r[19:0] & size_m;
	function automatic logic [31:0] mrg(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] s);
		for (int i = 0; i < 4; i++) begin
			if (s[i]) o[i*8 +: 8] = n[i*8 +: 8];
		end
		return o;
	endfunction
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mask_r <= 32'h00000000;
			upat_r <= 32'h00000000;
			lpat_r <= 32'h00000000;
			size_r <= 2'h0;
			imask_r <= 5'h00;
			quiet_r <= 3'h0;
			idle_r <= 4'h0;
		end else begin
			if (wr && adr_i == fpc_pkg::ADR_MASK) mask_r <= mrg(mask_r, dat_i, sel_i);
			if (wr && adr_i == fpc_pkg::ADR_UPAT) upat_r <= mrg(upat_r, dat_i, sel_i);
			if (wr && adr_i == fpc_pkg::ADR_LPAT) lpat_r <= mrg(lpat_r, dat_i, sel_i);
			if (wr && sel_i[0] && adr_i == fpc_pkg::ADR_CTRL) size_r <= dat_i[2:1];
			if (wr && sel_i[0] && adr_i == fpc_pkg::ADR_IMASK) imask_r <= dat_i[4:0];
			if (wr && (adr_i == fpc_pkg::ADR_CTRL || adr_i == fpc_pkg::ADR_MASK
				|| adr_i == fpc_pkg::ADR_UPAT || adr_i == fpc_pkg::ADR_LPAT)) quiet_r <= 3'h0;
			else if (quiet_r != 3'h7) quiet_r <= quiet_r + 3'h1;
			if (pulse_up_i || pulse_dn_i) idle_r <= 4'h0;
			else if (idle_r != 4'hF) idle_r <= idle_r + 4'h1;
		end
	end
	// ========
	// properties
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_ack_single: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
	a_ack_prompt: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("request not acked next cycle");
	a_ack_cause: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i))
		else $error("ack without request");
	a_dat_idle: assert property (!ack_o |-> dat_o == 32'h00000000)
		else $error("read data outside ack");
	a_unowned_follow: assert property (
		quiet_r >= 3'h2 |-> ((out_o ^ $past(prog_out_i)) & ~eff) == 20'h00000)
		else $error("unowned output not program value");
	a_owned_values: assert property (
		quiet_r >= 3'h4 |-> (out_o & eff) == ($past(out_o) & eff)
		|| (out_o & eff) == (upat_r[19:0] & eff) || (out_o & eff) == (lpat_r[19:0] & eff))
		else $error("owned output took a foreign value");
	a_owned_hold: assert property (
		quiet_r >= 3'h4 && idle_r >= 4'h8 |-> $stable(out_o & eff))
		else $error("owned output moved without count");
	a_irq_masked: assert property (imask_r == 5'h00 && $past(imask_r) == 5'h00 |-> !irq_o)
		else $error("interrupt with all masked");
endmodule
bind fpc_top fpc_props u_props (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
	.we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
	.pulse_up_i(pulse_up_i), .pulse_dn_i(pulse_dn_i), .prog_out_i(prog_out_i),
	.out_o(out_o), .irq_o(irq_o));

/* File: dv/counter_limits_and_output_mask_tb_top.sv */
`timescale 1ns/10ps
module counter_limits_and_output_mask_tb_top;
	logic        clk_i = 1'b0;
	logic        rst_i, cyc_i, stb_i, we_i, ack_o, irq_o, pu, pd, go, dn, busy;
	logic [7:0]  adr_i, num;
	logic [3:0]  sel_i, gap;
	logic [31:0] dat_i, dat_o, rd;
	logic [19:0] prog, out_o, e;
	int          err_count, compares, cyc_n;
	int          w[4] = '{4, 6, 10, 20};
	always #2 clk_i = ~clk_i;
	fpc_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.pulse_up_i(pu), .pulse_dn_i(pd), .prog_out_i(prog), .out_o(out_o), .irq_o(irq_o));
	fpc_field_model u_field (.clk_i(clk_i), .go_i(go), .dn_i(dn), .num_i(num), .gap_i(gap),
		.pulse_up_o(pu), .pulse_dn_o(pd), .prog_o(prog), .busy_o(busy));
	// ========
	// shared tasks
	task automatic test_done();
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= wr;
		adr_i <= a;
		dat_i <= d;
		@(posedge clk_i);
		// only the bench timeout ends a wait for ack
		while (ack_o !== 1'b1) begin
			@(posedge clk_i);
		end
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		wb(1'b0, a, 32'h00000000);
		chk(rd, exp);
	endtask
	task automatic pulse(input logic d, input logic [7:0] n);
		dn <= d;
		num <= n;
		go <= 1'b1;
		@(posedge clk_i);
		go <= 1'b0;
		repeat (2) @(posedge clk_i);
		while (busy) @(posedge clk_i);
		repeat (6) @(posedge clk_i);
	endtask
	task automatic irqchk(input logic exp);
		repeat (2) @(posedge clk_i);
		chk({31'h0, irq_o}, {31'h0, exp});
	endtask
	// ========
	// scenarios
	task automatic t_reset();
		rdchk(fpc_pkg::ADR_STAT, 32'h00000000);
		rdchk(fpc_pkg::ADR_LCL, fpc_pkg::LCL_RST);
		rdchk(fpc_pkg::ADR_MASK, 32'h00000000);
		rdchk(8'h30, 32'h00000000);
		$display("t_reset done");
	endtask
	task automatic t_fault();
		wb(1'b1, fpc_pkg::ADR_LCL, 32'h0000000A);
		wb(1'b1, fpc_pkg::ADR_LTV, 32'h00000005);
		wb(1'b1, fpc_pkg::ADR_CTRL, 32'h00000001);
		rdchk(fpc_pkg::ADR_STAT, 32'h00000012);
		wb(1'b1, fpc_pkg::ADR_LTV, 32'h00000014);
		wb(1'b1, fpc_pkg::ADR_STAT, 32'h00000002);
		rdchk(fpc_pkg::ADR_STAT, 32'h00000011);
		rdchk(fpc_pkg::ADR_ISTAT, 32'h00000010);
		// upper target above upper limit reports reason code 2
		wb(1'b1, fpc_pkg::ADR_UCL, 32'h00000064);
		rdchk(fpc_pkg::ADR_STAT, 32'h00000022);
		$display("t_fault done");
	endtask
	task automatic t_wrap();
		wb(1'b1, fpc_pkg::ADR_UTV, 32'h00000003);
		wb(1'b1, fpc_pkg::ADR_UCL, 32'h00000005);
		wb(1'b1, fpc_pkg::ADR_LCL, 32'hFFFFFFFB);
		wb(1'b1, fpc_pkg::ADR_LTV, 32'hFFFFFFFD);
		wb(1'b1, fpc_pkg::ADR_STAT, 32'h00000002);
		// the upper limit write above left lower >= upper for a moment: code 3 held
		rdchk(fpc_pkg::ADR_STAT, 32'h00000031);
		wb(1'b1, fpc_pkg::ADR_ISTAT, 32'h0000001F);
		wb(1'b1, fpc_pkg::ADR_IMASK, 32'h00000003);
		wb(1'b1, fpc_pkg::ADR_ACC, 32'hFFFFFFFC);
		pulse(1'b1, 8'd2);
		rdchk(fpc_pkg::ADR_ACC, 32'h00000005);
		rdchk(fpc_pkg::ADR_ISTAT, 32'h00000002);
		irqchk(1'b1);
		wb(1'b1, fpc_pkg::ADR_IMASK, 32'h00000000);
		irqchk(1'b0);
		wb(1'b1, fpc_pkg::ADR_ISTAT, 32'h00000002);
		wb(1'b1, fpc_pkg::ADR_IMASK, 32'h00000003);
		irqchk(1'b0);
		wb(1'b1, fpc_pkg::ADR_ACC, 32'h00000004);
		pulse(1'b0, 8'd2);
		rdchk(fpc_pkg::ADR_ACC, 32'hFFFFFFFB);
		rdchk(fpc_pkg::ADR_ISTAT, 32'h00000001);
		irqchk(1'b1);
		wb(1'b1, fpc_pkg::ADR_ISTAT, 32'h00000001);
		irqchk(1'b0);
		$display("t_wrap done");
	endtask
	task automatic t_outputs();
		wb(1'b1, fpc_pkg::ADR_CTRL, 32'h00000000);
		wb(1'b1, fpc_pkg::ADR_MASK, 32'h0005A5A5);
		wb(1'b1, fpc_pkg::ADR_UPAT, 32'h0003C3C3);
		wb(1'b1, fpc_pkg::ADR_LPAT, 32'h000C3C3C);
		for (int s = 0; s < 4; s++) begin
			e = 20'h5A5A5 & ~(20'hFFFFF << w[s]);
			wb(1'b1, fpc_pkg::ADR_CTRL, 32'(s * 2 + 1));
			wb(1'b1, fpc_pkg::ADR_ACC, 32'h00000002);
			pulse(1'b0, 8'd1);
			chk({12'h000, out_o & e}, {12'h000, 20'h3C3C3 & e});
			wb(1'b1, fpc_pkg::ADR_ACC, 32'hFFFFFFFE);
			pulse(1'b1, 8'd1);
			chk({12'h000, out_o & e}, {12'h000, 20'hC3C3C & e});
		end
		gap <= 4'h3;
		wb(1'b1, fpc_pkg::ADR_LPAT, 32'h0000000F);
		wb(1'b1, fpc_pkg::ADR_ACC, 32'hFFFFFFFE);
		pulse(1'b1, 8'd1);
		chk({12'h000, out_o & e}, 32'h00000005);
		// both target hits left their event bits, nothing wrapped
		rdchk(fpc_pkg::ADR_ISTAT, 32'h0000000C);
		$display("t_outputs done");
	endtask
	// ========
	// main sequence and timeout
	always @(posedge clk_i) begin
		cyc_n++;
		if (cyc_n > 20000) begin
			err_count++;
			test_done();
		end
	end
	initial begin
		rst_i = 1'b1;
		cyc_i = 1'b0;
		stb_i = 1'b0;
		we_i = 1'b0;
		adr_i = 8'h00;
		sel_i = 4'hF;
		dat_i = 32'h00000000;
		go = 1'b0;
		dn = 1'b0;
		num = 8'h00;
		gap = 4'h0;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_fault();
		t_wrap();
		t_outputs();
		test_done();
	end
endmodule
